// [rtl/gdcs_pkg.sv]
// Constants for the single-PWM gate-drive commutation sequencer.
// Assumes a 200 MHz core clock and an APB register master.
// Contract
// - Diode freewheel decode: 14 states, PWM phase low gate off, 1110 align, 0000 stop.
// - Freewheel select bit picks active (low gate = inverted PWM) or diode freewheel.
// - PWM on phase A high input; three pins load commutation register; C low ignored.
// - Overlap input held high across a change; overlap state kept until it falls.
// - Charge pump off while enable low; rising enable starts power-up sequence.
// - Low-side regulator off while enable low; part of power-up sequence.
// - Charge pump under/overvoltage monitored; protective action and readable status.
// - Low-side supply undervoltage monitored; action and readable status.
// - Twelve gate-current levels; one high-side setting, one low-side setting.
// - Gate-current levels writable in standby and operating states.
// - Incoming gate enabled only after monitor shows outgoing gate off.
// - Configured dead time added only after handshake completes.
// - Gate command applies strong drive and starts transition timer.
// - Strong drive limited to configured duration.
// - Target not reached at expiry: fault, gate disabled; else hold current.
package gdcs_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] GDCS_CTRL_OFS = 8'h00;
    localparam logic [7:0] GDCS_DRIVE_OFS = 8'h04;
    localparam logic [7:0] GDCS_STAT_OFS = 8'h08;
    localparam logic [7:0] GDCS_MASK_OFS = 8'h0c;
    localparam logic [7:0] GDCS_STATE_OFS = 8'h10;
    // CTRL fields
    localparam int GDCS_CTRL_EN_BIT = 0;
    localparam int GDCS_CTRL_FW_BIT = 1;
    // DRIVE fields: high level, low level, timer, dead time
    localparam int GDCS_HI_LVL_POS = 0;
    localparam int GDCS_LO_LVL_POS = 4;
    localparam int GDCS_TMR_POS = 8;
    localparam int GDCS_DEAD_POS = 16;
    localparam int GDCS_LVL_COUNT = 12;
    // Status bits
    localparam int GDCS_ST_PUMP_UV = 0;
    localparam int GDCS_ST_PUMP_OV = 1;
    localparam int GDCS_ST_LSUP_UV = 2;
    localparam int GDCS_ST_GFAULT = 3;
    localparam int GDCS_ST_READY = 4;
    localparam int GDCS_NSTAT = 5;
    // Reset values
    localparam logic [31:0] GDCS_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] GDCS_DRIVE_RST = 32'h0004_ff77;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int GDCS_CLK_MHZ = 200;
    localparam int GDCS_PWRUP_US = 1000;
    localparam int GDCS_PWRUP_CYC = GDCS_PWRUP_US * GDCS_CLK_MHZ;
    // Commutation codes
    localparam logic [3:0] GDCS_CODE_ALIGN = 4'he;
    localparam logic [3:0] GDCS_CODE_STOP = 4'h0;
    typedef enum logic [1:0] {GDCS_OFF, GDCS_PWRUP, GDCS_RUN} gdcs_pwr_t;
    typedef enum logic [2:0] {GDCS_IDLE, GDCS_WAIT_OFF, GDCS_DEAD, GDCS_STRONG, GDCS_HOLD,
                              GDCS_FAULT} gdcs_ph_t;
endpackage : gdcs_pkg

// [rtl/gdcs_top.sv]
// Single-PWM commutation decoder and per-phase gate-drive sequencer.
// Assumes pin inputs are asynchronous and the APB master shares CLK.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module gdcs_top import gdcs_pkg::*; #(
    parameter int PWRUP_CYCLES = GDCS_PWRUP_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [2:0] HIGH_SIDE_INPUT,
    input wire logic [2:0] LOW_SIDE_INPUT,
    input wire logic [2:0] HIGH_GATE_ON,
    input wire logic [2:0] LOW_GATE_ON,
    input wire logic PUMP_UV,
    input wire logic PUMP_OV,
    input wire logic LSUP_UV,
    output logic [2:0] HIGH_GATE_OUT,
    output logic [2:0] LOW_GATE_OUT,
    output logic [2:0] HIGH_STRONG,
    output logic [2:0] LOW_STRONG,
    output logic [3:0] HIGH_CURRENT_LEVEL,
    output logic [3:0] LOW_CURRENT_LEVEL,
    output logic PUMP_EN,
    output logic LSUP_EN,
    output logic IRQ
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (PWRUP_CYCLES < 2) begin : g_pwrup_chk
        $error("PWRUP_CYCLES too small");
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Two flops: every pin here is asynchronous to CLK
    localparam int NSYNC = 15;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {LSUP_UV, PUMP_OV, PUMP_UV, LOW_GATE_ON, HIGH_GATE_ON, LOW_SIDE_INPUT, HIGH_SIDE_INPUT};
            sync2_r <= sync1_r;
        end
    end
    logic [2:0] hin, lin, hmon, lmon;
    logic pump_uv, pump_ov, lsup_uv;
    assign hin = sync2_r[2:0];
    assign lin = sync2_r[5:3];
    assign hmon = sync2_r[8:6];
    assign lmon = sync2_r[11:9];
    assign pump_uv = sync2_r[12];
    assign pump_ov = sync2_r[13];
    assign lsup_uv = sync2_r[14];

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    logic [31:0] ctrl_r, drive_r;
    logic [GDCS_NSTAT-1:0] stat_r, mask_r, ev;
    logic wr, rd_hit;
    assign wr = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign rd_hit = (PADDR == GDCS_CTRL_OFS) || (PADDR == GDCS_DRIVE_OFS) || (PADDR == GDCS_STAT_OFS)
                    || (PADDR == GDCS_MASK_OFS) || (PADDR == GDCS_STATE_OFS);
    // Unmapped access errors out and its write is dropped
    assign PSLVERR = PSEL && PENABLE && !rd_hit;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_r <= GDCS_CTRL_RST;
            drive_r <= GDCS_DRIVE_RST;
            mask_r <= '0;
        end else if (wr) begin
            if (PADDR == GDCS_CTRL_OFS) begin
                ctrl_r <= {30'h0, PWDATA[1:0]};
            end
            if (PADDR == GDCS_DRIVE_OFS) begin
                drive_r[23:16] <= PWDATA[23:16];
                drive_r[15:8] <= (PWDATA[15:8] == 8'h00) ? 8'h01 : PWDATA[15:8];
                drive_r[7:4] <= (PWDATA[7:4] >= 4'(GDCS_LVL_COUNT)) ? 4'hb : PWDATA[7:4];
                drive_r[3:0] <= (PWDATA[3:0] >= 4'(GDCS_LVL_COUNT)) ? 4'hb : PWDATA[3:0];
            end
            if (PADDR == GDCS_MASK_OFS) begin
                mask_r <= PWDATA[GDCS_NSTAT-1:0];
            end
        end
    end
    // ----------------------------------------
    // Status and interrupt
    // ----------------------------------------
    // Set wins over write-one-to-clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~((wr && PADDR == GDCS_STAT_OFS) ? PWDATA[GDCS_NSTAT-1:0] : '0)) | ev;
        end
    end
    assign IRQ = |(stat_r & mask_r);
    assign HIGH_CURRENT_LEVEL = drive_r[GDCS_HI_LVL_POS+:4];
    assign LOW_CURRENT_LEVEL = drive_r[GDCS_LO_LVL_POS+:4];

    // ----------------------------------------
    // Supply power-up sequence
    // ----------------------------------------
    gdcs_pwr_t pwr_r;
    logic [31:0] pcnt_r;
    logic en_d_r;
    logic en;
    assign en = ctrl_r[GDCS_CTRL_EN_BIT];
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pwr_r <= GDCS_OFF;
            pcnt_r <= '0;
            en_d_r <= 1'b0;
        end else begin
            en_d_r <= en;
            case (pwr_r)
                GDCS_OFF: begin
                    pcnt_r <= '0;
                    if (en && !en_d_r) begin
                        pwr_r <= GDCS_PWRUP;
                    end
                end
                GDCS_PWRUP: begin
                    pcnt_r <= pcnt_r + 32'h1;
                    if (!en) begin
                        pwr_r <= GDCS_OFF;
                    end else if (pcnt_r == 32'(PWRUP_CYCLES - 1)) begin
                        pwr_r <= GDCS_RUN;
                    end
                end
                GDCS_RUN: begin
                    if (!en) begin
                        pwr_r <= GDCS_OFF;
                    end
                end
                default: pwr_r <= GDCS_OFF;
            endcase
        end
    end
    assign PUMP_EN = (pwr_r != GDCS_OFF);
    assign LSUP_EN = (pwr_r != GDCS_OFF);
    logic run, sup_fault;
    assign sup_fault = pump_uv || pump_ov || lsup_uv;
    assign run = (pwr_r == GDCS_RUN) && !sup_fault;

    // ----------------------------------------
    // Commutation register and decode
    // ----------------------------------------
    logic [2:0] comm_r;
    logic [3:0] code;
    logic pwm, overlap;
    assign pwm = hin[0];
    assign overlap = hin[2];
    assign code = {comm_r, overlap};
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            comm_r <= '0;
        end else begin
            comm_r <= {lin[0], hin[1], lin[1]};
        end
    end
    // Per phase: 0 off, 1 pwm, 2 low on
    logic [1:0] ph_mode [3];
    always_comb begin
        ph_mode[0] = 2'd0;
        ph_mode[1] = 2'd0;
        ph_mode[2] = 2'd0;
        case (code)
            4'h6: begin ph_mode[0] = 2'd1; ph_mode[1] = 2'd2; end
            4'h5: begin ph_mode[0] = 2'd1; ph_mode[1] = 2'd2; ph_mode[2] = 2'd1; end
            4'h4: begin ph_mode[1] = 2'd2; ph_mode[2] = 2'd1; end
            4'hd: begin ph_mode[0] = 2'd2; ph_mode[1] = 2'd2; ph_mode[2] = 2'd1; end
            4'hc: begin ph_mode[0] = 2'd2; ph_mode[2] = 2'd1; end
            4'h9: begin ph_mode[0] = 2'd2; ph_mode[1] = 2'd1; ph_mode[2] = 2'd1; end
            4'h8: begin ph_mode[0] = 2'd2; ph_mode[1] = 2'd1; end
            4'hb: begin ph_mode[0] = 2'd2; ph_mode[1] = 2'd1; ph_mode[2] = 2'd2; end
            4'ha: begin ph_mode[1] = 2'd1; ph_mode[2] = 2'd2; end
            4'h3: begin ph_mode[0] = 2'd1; ph_mode[1] = 2'd1; ph_mode[2] = 2'd2; end
            4'h2: begin ph_mode[0] = 2'd1; ph_mode[2] = 2'd2; end
            4'h7: begin ph_mode[0] = 2'd1; ph_mode[1] = 2'd2; ph_mode[2] = 2'd2; end
            GDCS_CODE_ALIGN: begin ph_mode[0] = 2'd1; ph_mode[1] = 2'd2; ph_mode[2] = 2'd2; end
            default: ;
        endcase
    end

    // ----------------------------------------
    // Per-phase gate sequencer
    // ----------------------------------------
    logic fw_active;
    assign fw_active = ctrl_r[GDCS_CTRL_FW_BIT];
    logic [2:0] gfault;
    logic [5:0] ph_state_flat;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ph
            logic want_h, want_l;
            // Diode freewheel keeps low gate off
            assign want_h = run && (ph_mode[g] == 2'd1) && pwm;
            assign want_l = run && ((ph_mode[g] == 2'd2) || (ph_mode[g] == 2'd1 && fw_active && !pwm));
            gdcs_ph_t st_r;
            logic h_r, l_r, tgt_h_r, tgt_l_r, prev_want_h_r, prev_want_l_r;
            logic [7:0] cnt_r;
            logic cmd_chg;
            assign cmd_chg = (want_h != prev_want_h_r) || (want_l != prev_want_l_r);
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    st_r <= GDCS_IDLE;
                    h_r <= 1'b0;
                    l_r <= 1'b0;
                    tgt_h_r <= 1'b0;
                    tgt_l_r <= 1'b0;
                    prev_want_h_r <= 1'b0;
                    prev_want_l_r <= 1'b0;
                    cnt_r <= '0;
                end else begin
                    prev_want_h_r <= want_h;
                    prev_want_l_r <= want_l;
                    if (!run) begin
                        st_r <= GDCS_IDLE;
                        h_r <= 1'b0;
                        l_r <= 1'b0;
                    end else if (cmd_chg && st_r != GDCS_FAULT) begin
                        tgt_h_r <= want_h;
                        tgt_l_r <= want_l;
                        // Monitor decides: a gate just commanded off may still conduct
                        if ((want_h && (l_r || lmon[g])) || (want_l && (h_r || hmon[g]))) begin
                            h_r <= 1'b0;
                            l_r <= 1'b0;
                            st_r <= GDCS_WAIT_OFF;
                        end else begin
                            h_r <= want_h;
                            l_r <= want_l;
                            cnt_r <= drive_r[GDCS_TMR_POS+:8];
                            st_r <= GDCS_STRONG;
                        end
                    end else begin
                        case (st_r)
                            GDCS_WAIT_OFF: begin
                                if (!hmon[g] && !lmon[g]) begin
                                    cnt_r <= drive_r[GDCS_DEAD_POS+:8];
                                    st_r <= GDCS_DEAD;
                                end
                            end
                            GDCS_DEAD: begin
                                if (cnt_r == 8'h00) begin
                                    h_r <= tgt_h_r;
                                    l_r <= tgt_l_r;
                                    cnt_r <= drive_r[GDCS_TMR_POS+:8];
                                    st_r <= GDCS_STRONG;
                                end else begin
                                    cnt_r <= cnt_r - 8'h01;
                                end
                            end
                            GDCS_STRONG: begin
                                if (cnt_r > 8'h01) begin
                                    cnt_r <= cnt_r - 8'h01;
                                end else if (hmon[g] == h_r && lmon[g] == l_r) begin
                                    st_r <= GDCS_HOLD;
                                end else begin
                                    h_r <= 1'b0;
                                    l_r <= 1'b0;
                                    st_r <= GDCS_FAULT;
                                end
                            end
                            GDCS_HOLD, GDCS_IDLE, GDCS_FAULT: ;
                            default: st_r <= GDCS_IDLE;
                        endcase
                    end
                end
            end
            assign HIGH_GATE_OUT[g] = h_r;
            assign LOW_GATE_OUT[g] = l_r;
            assign HIGH_STRONG[g] = (st_r == GDCS_STRONG) && h_r;
            assign LOW_STRONG[g] = (st_r == GDCS_STRONG) && l_r;
            assign gfault[g] = (st_r == GDCS_STRONG) && (cnt_r <= 8'h01) && !(hmon[g] == h_r && lmon[g] == l_r)
                               && run && !cmd_chg;
            assign ph_state_flat[2*g+:2] = ph_mode[g];
        end
    endgenerate

    // Fault stays latched until enable is cleared or a supply fault drops run; cleared by leaving run.
    logic run_d_r;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= (pwr_r == GDCS_RUN);
        end
    end
    assign ev = {(pwr_r == GDCS_RUN) && !run_d_r, |gfault, lsup_uv, pump_ov, pump_uv};

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Captured in setup phase so the access phase needs no wait state
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= '0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                GDCS_CTRL_OFS: PRDATA <= ctrl_r;
                GDCS_DRIVE_OFS: PRDATA <= drive_r;
                GDCS_STAT_OFS: PRDATA <= {27'h0, stat_r};
                GDCS_MASK_OFS: PRDATA <= {27'h0, mask_r};
                GDCS_STATE_OFS: PRDATA <= {20'h0, pwr_r, code, ph_state_flat};
                default: PRDATA <= '0;
            endcase
        end
    end
endmodule : gdcs_top

// [tb/gdcs_mcu_model.sv]
// Controller-side model: drives PWM and code pins, echoes gates as the monitors do.
// Assumes the bench holds code, PWM and monitor lag; stuck models a shorted gate.
`timescale 1ns/100ps
module gdcs_mcu_model (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [3:0] code,
    input wire logic pwm,
    input wire logic c_low,
    input wire logic [3:0] lag,
    input wire logic [2:0] stuck,
    input wire logic [2:0] high_gate_out,
    input wire logic [2:0] low_gate_out,
    output logic [2:0] high_side_input,
    output logic [2:0] low_side_input,
    output logic [2:0] high_gate_on,
    output logic [2:0] low_gate_on
);
    logic [47:0] hi_hist_r;
    logic [47:0] lo_hist_r;
    assign high_side_input = {code[0], code[2], pwm};
    // Phase C low pin kept busy
    assign low_side_input = {c_low, code[1], code[3]};
    // Gate voltage follows the command lag+1 cycles later
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            hi_hist_r <= '0;
            lo_hist_r <= '0;
        end else begin
            hi_hist_r <= {hi_hist_r[44:0], high_gate_out};
            lo_hist_r <= {lo_hist_r[44:0], low_gate_out};
        end
    end
    assign high_gate_on = hi_hist_r[3 * lag +: 3] & ~stuck;
    assign low_gate_on = lo_hist_r[3 * lag +: 3];
endmodule : gdcs_mcu_model

// [tb/gdcs_top_props.sv]
// Checker for the gate-drive sequencer top: supply gating, handshake, strong drive.
// Assumes one clock domain; bound into every gdcs_top instance below.
`timescale 1ns/100ps
module gdcs_top_props import gdcs_pkg::*; #(
    parameter int PWRUP_CYCLES = GDCS_PWRUP_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [2:0] HIGH_GATE_ON,
    input wire logic [2:0] LOW_GATE_ON,
    input wire logic PUMP_UV,
    input wire logic PUMP_OV,
    input wire logic LSUP_UV,
    input wire logic [2:0] HIGH_GATE_OUT,
    input wire logic [2:0] LOW_GATE_OUT,
    input wire logic [2:0] HIGH_STRONG,
    input wire logic [3:0] HIGH_CURRENT_LEVEL,
    input wire logic [3:0] LOW_CURRENT_LEVEL,
    input wire logic PUMP_EN,
    input wire logic LSUP_EN,
    input wire logic IRQ
);
    logic ctrl_wr;
    int pwr_cnt_r;
    int str_cnt_r;
    assign ctrl_wr = PSEL && PENABLE && PWRITE && (PADDR == GDCS_CTRL_OFS);
    // Counters instead of long repetitions, which tools unroll
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pwr_cnt_r <= 0;
        end else begin
            pwr_cnt_r <= PUMP_EN ? pwr_cnt_r + 1 : 0;
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            str_cnt_r <= 0;
        end else begin
            str_cnt_r <= HIGH_STRONG[0] ? str_cnt_r + 1 : 0;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    AST_EN_OFF: assert property (ctrl_wr && !PWDATA[GDCS_CTRL_EN_BIT] |-> ##[1:3] !PUMP_EN && !LSUP_EN)
        else $error("supplies stay on after enable cleared");
    AST_EN_ON: assert property (ctrl_wr && PWDATA[GDCS_CTRL_EN_BIT] && !PUMP_EN |-> ##[1:3] PUMP_EN && LSUP_EN)
        else $error("power-up not started by enable");
    AST_PWRUP_OFF: assert property (PUMP_EN && pwr_cnt_r < PWRUP_CYCLES - 1 |-> (HIGH_GATE_OUT | LOW_GATE_OUT) == 3'h0)
        else $error("gate driven during power-up");
    AST_PUMP_FAULT: assert property ((PUMP_UV || PUMP_OV) [*6] |-> (HIGH_GATE_OUT | LOW_GATE_OUT) == 3'h0)
        else $error("gates on during pump fault");
    AST_LSUP_FAULT: assert property (LSUP_UV [*6] |-> (HIGH_GATE_OUT | LOW_GATE_OUT) == 3'h0)
        else $error("gates on during low supply fault");
    AST_LOW_AFTER_HIGH: assert property ($rose(LOW_GATE_OUT[0]) |-> !HIGH_GATE_OUT[0] && !$past(HIGH_GATE_ON[0], 2))
        else $error("low gate on before high gate seen off");
    AST_HIGH_AFTER_LOW: assert property ($rose(HIGH_GATE_OUT[0]) |-> !LOW_GATE_OUT[0] && !$past(LOW_GATE_ON[0], 2))
        else $error("high gate on before low gate seen off");
    AST_STRONG_ON: assert property ($rose(HIGH_GATE_OUT[0]) |-> HIGH_STRONG[0])
        else $error("no strong drive at turn-on");
    AST_STRONG_LIMIT: assert property (str_cnt_r <= 255)
        else $error("strong drive beyond timer range");
    AST_LEVEL_RANGE: assert property (HIGH_CURRENT_LEVEL < 4'hc && LOW_CURRENT_LEVEL < 4'hc)
        else $error("current level out of range");
    cover property ($rose(LOW_GATE_OUT[0]));
    cover property ($fell(HIGH_STRONG[0]));
    cover property ($rose(IRQ));
endmodule : gdcs_top_props

bind gdcs_top gdcs_top_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) gdcs_top_props_i (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .HIGH_GATE_ON(HIGH_GATE_ON), .LOW_GATE_ON(LOW_GATE_ON), .PUMP_UV(PUMP_UV),
    .PUMP_OV(PUMP_OV), .LSUP_UV(LSUP_UV), .HIGH_GATE_OUT(HIGH_GATE_OUT), .LOW_GATE_OUT(LOW_GATE_OUT),
    .HIGH_STRONG(HIGH_STRONG), .HIGH_CURRENT_LEVEL(HIGH_CURRENT_LEVEL),
    .LOW_CURRENT_LEVEL(LOW_CURRENT_LEVEL), .PUMP_EN(PUMP_EN), .LSUP_EN(LSUP_EN), .IRQ(IRQ)
);

// [tb/tb.sv]
// Self-checking bench for the gate-drive sequencer top.
// Assumes the controller model and a power-up count shortened to PWRUP cycles.
`timescale 1ns/100ps
module tb import gdcs_pkg::*;;
    localparam int PWRUP = 20;
    localparam logic [5:0] MODE_TBL [16] = '{6'h00, 6'h00, 6'h21, 6'h25, 6'h18, 6'h19, 6'h09, 6'h29,
        6'h06, 6'h16, 6'h24, 6'h26, 6'h12, 6'h1a, 6'h29, 6'h00};
    logic clk, rst, psel, penable, pwrite, pslverr, pready, irq, pump_en, lsup_en, pwm, c_low, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] code, lag, hi_lvl, lo_lvl;
    logic [2:0] sup, stuck, hsi, lsi, hg_on, lg_on, hg, lg, hs, ls;
    int fails, samples_checked, n;
    gdcs_top #(.PWRUP_CYCLES(PWRUP)) gdcs_top_i (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .HIGH_SIDE_INPUT(hsi), .LOW_SIDE_INPUT(lsi), .HIGH_GATE_ON(hg_on), .LOW_GATE_ON(lg_on),
        .PUMP_UV(sup[0]), .PUMP_OV(sup[1]), .LSUP_UV(sup[2]), .HIGH_GATE_OUT(hg), .LOW_GATE_OUT(lg),
        .HIGH_STRONG(hs), .LOW_STRONG(ls), .HIGH_CURRENT_LEVEL(hi_lvl), .LOW_CURRENT_LEVEL(lo_lvl),
        .PUMP_EN(pump_en), .LSUP_EN(lsup_en), .IRQ(irq)
    );
    gdcs_mcu_model gdcs_mcu_model_i (
        .CLK(clk), .RST(rst), .code(code), .pwm(pwm), .c_low(c_low), .lag(lag), .stuck(stuck),
        .high_gate_out(hg), .low_gate_out(lg), .high_side_input(hsi), .low_side_input(lsi),
        .high_gate_on(hg_on), .low_gate_on(lg_on)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic t_regs();
        apb(1'b0, GDCS_DRIVE_OFS, 32'h0);
        chk("drive reset", GDCS_DRIVE_RST, q);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, {q[30:0], e});
        apb(1'b1, GDCS_DRIVE_OFS, 32'h0003_10dc);
        @(posedge clk);
        chk("standby levels", 32'hbb, 32'({lo_lvl, hi_lvl}));
    endtask : t_regs
    task automatic t_power();
        chk("supplies idle", 32'h0, 32'({pump_en, lsup_en}));
        apb(1'b1, GDCS_CTRL_OFS, 32'h1);
        apb(1'b0, GDCS_STAT_OFS, 32'h0);
        chk("early ready", 32'h0, 32'(q[GDCS_ST_READY]));
        chk("supplies on", 32'h3, 32'({pump_en, lsup_en}));
        repeat (PWRUP + 10) @(posedge clk);
        apb(1'b0, GDCS_STAT_OFS, 32'h0);
        chk("ready", 32'h1, 32'(q[GDCS_ST_READY]));
    endtask : t_power
    task automatic t_decode();
        logic [2:0] eh, el;
        logic [1:0] m;
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, GDCS_CTRL_OFS, {30'h0, f[0], 1'b1});
            for (int c = 0; c < 16; c++) begin
                for (int p = 1; p >= 0; p--) begin
                    code <= c[3:0];
                    pwm <= p[0];
                    c_low <= ~c_low;
                    repeat (40) @(posedge clk);
                    for (int k = 0; k < 3; k++) begin
                        m = MODE_TBL[c][2 * k +: 2];
                        eh[k] = (m == 2'd1) && p[0];
                        el[k] = (m == 2'd2) || ((m == 2'd1) && f[0] && !p[0]);
                    end
                    chk("gates", 32'({el, eh}), 32'({lg, hg}));
                    apb(1'b0, GDCS_STATE_OFS, 32'h0);
                    chk("state", 32'({c[3:0], MODE_TBL[c]}), 32'(q[9:0]));
                end
            end
        end
    endtask : t_decode
    task automatic t_drive();
        code <= 4'h6;
        pwm <= 1'b1;
        repeat (40) @(posedge clk);
        lag <= 4'h8;
        pwm <= 1'b0;
        for (n = 0; hg_on[0] !== 1'b0 && n < 50; n++) @(posedge clk);
        for (n = 0; lg[0] !== 1'b1 && n < 50; n++) @(posedge clk);
        chk("dead after handshake", 32'h1, 32'(n >= 4 && n <= 10));
        for (n = 0; ls[0] === 1'b1 && n < 300; n++) @(posedge clk);
        chk("strong span", 32'd16, n);
        apb(1'b1, GDCS_DRIVE_OFS, 32'h0003_c852);
        @(posedge clk);
        chk("run levels", 32'h52, 32'({lo_lvl, hi_lvl}));
        pwm <= 1'b1;
        for (n = 0; hs[0] !== 1'b1 && n < 60; n++) @(posedge clk);
        repeat (10) @(posedge clk);
        pwm <= 1'b0;
        for (n = 0; hs[0] === 1'b1 && n < 300; n++) @(posedge clk);
        chk("strong cut", 32'h1, 32'(n <= 6));
        lag <= 4'h2;
        pwm <= 1'b1;
        apb(1'b1, GDCS_DRIVE_OFS, 32'h0003_1052);
    endtask : t_drive
    task automatic t_supply();
        for (int i = 0; i < 3; i++) begin
            repeat (40) @(posedge clk);
            sup <= 3'b001 << i;
            repeat (8) @(posedge clk);
            chk("gates in fault", 32'h0, 32'({lg, hg}));
            apb(1'b0, GDCS_STAT_OFS, 32'h0);
            chk("fault status", 32'(3'b001 << i), 32'(q[2:0]));
            chk("irq masked", 32'h0, 32'(irq));
            apb(1'b1, GDCS_MASK_OFS, 32'(3'b001 << i));
            @(posedge clk);
            chk("irq raised", 32'h1, 32'(irq));
            sup <= 3'h0;
            apb(1'b1, GDCS_STAT_OFS, 32'(3'b001 << i));
            @(posedge clk);
            chk("irq cleared", 32'h0, 32'(irq));
            apb(1'b1, GDCS_MASK_OFS, 32'h0);
        end
    endtask : t_supply
    task automatic t_fault();
        pwm <= 1'b0;
        apb(1'b1, GDCS_CTRL_OFS, 32'h0);
        repeat (2) @(posedge clk);
        chk("supplies off", 32'h0, 32'({pump_en, lsup_en}));
        apb(1'b1, GDCS_CTRL_OFS, 32'h3);
        repeat (PWRUP + 40) @(posedge clk);
        stuck <= 3'h1;
        pwm <= 1'b1;
        repeat (80) @(posedge clk);
        chk("faulted gate", 32'h0, 32'(hg[0]));
        apb(1'b0, GDCS_STAT_OFS, 32'h0);
        chk("gate fault", 32'h1, 32'(q[GDCS_ST_GFAULT]));
    endtask : t_fault
    task automatic end_sim();
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        end_sim();
    end
    initial begin
        {rst, psel, penable, pwrite, pwm, c_low} = 6'h20;
        {paddr, pwdata, code, lag, sup, stuck} = '0;
        lag = 4'h2;
        fails = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_power();
        t_decode();
        t_drive();
        t_supply();
        t_fault();
        end_sim();
    end
endmodule : tb
